// [include/adc_format_pkg.sv]
/*
 * Constants for the converter result formatting and pin configuration block:
 * register indices, implemented-bit masks, reset values, field positions and
 * the output format encoding.
 * Assumes a 32-bit APB bus whose byte address is four times a register index.
 */
package adc_format_pkg;

    // ========================================================================
    // Register indices (byte address is index * 4)
    // ========================================================================
    localparam int          BUF_COUNT     = 16;
    localparam logic [15:0] BUF_IDX [BUF_COUNT] = '{
        16'h0280, 16'h0282, 16'h0284, 16'h0286,
        16'h0288, 16'h028A, 16'h028C, 16'h028E,
        16'h0530, 16'h0292, 16'h0294, 16'h0296,
        16'h0298, 16'h029A, 16'h029C, 16'h029E
    };
    localparam logic [15:0] CTRL_ONE_IDX  = 16'h02A0;
    localparam logic [15:0] CTRL_TWO_IDX  = 16'h02A2;
    localparam logic [15:0] CTRL_THR_IDX  = 16'h02A4;
    localparam logic [15:0] CHAN_SEL_IDX  = 16'h02A6;
    localparam logic [15:0] PIN_CFG_IDX   = 16'h02A8;
    localparam logic [15:0] SCAN_SEL_IDX  = 16'h02AA;

    // ========================================================================
    // Implemented bits and reset values
    // ========================================================================
    localparam logic [15:0] CTRL_ONE_MASK = 16'hA3E7;
    localparam logic [15:0] CTRL_TWO_MASK = 16'h7487;
    localparam logic [15:0] CTRL_THR_MASK = 16'h1FBF;
    localparam logic [15:0] CHAN_SEL_MASK = 16'h1F1F;
    localparam logic [15:0] FULL_MASK     = 16'hFFFF;
    localparam logic [15:0] REG_RESET     = 16'h0000;

    // ========================================================================
    // Field positions
    // ========================================================================
    localparam int FORM_LSB   = 8;
    localparam int ON_BIT     = 15;
    localparam int DONE_BIT   = 0;
    localparam int CHSA_LSB   = 0;
    localparam int CHSB_LSB   = 8;
    localparam int RESULT_W   = 12;
    localparam int WORD_W     = 16;
    localparam int PAD_W      = WORD_W - RESULT_W;

    // ========================================================================
    // Output format encoding
    // ========================================================================
    typedef enum logic [1:0] {
        FMT_INTEGER        = 2'h0,
        FMT_SIGNED_INTEGER = 2'h1,
        FMT_FRACTIONAL     = 2'h2,
        FMT_SIGNED_FRACT   = 2'h3
    } format_type;

endpackage : adc_format_pkg

// [src/adc_result_format.sv]
/*
 * Digital side of a 12-bit converter: result buffer words, the control,
 * channel-select, pin-configuration and scan-select registers, the four
 * bus read formats, and the per-pin analog/digital decision.
 * Assumes an APB master on core_clk, a sequencer on core_clk that writes
 * results, port direction bits from the port logic on core_clk, and raw
 * pin levels that are asynchronous.
 */
// Our own choice: the APB interface to the registers.
// What this block does
// [RULE1] Reads place result in selected format
// [RULE2] Software sets direction to input first
// [RULE3] Output-direction analog pin converts driven level
// [RULE4] Conversion ignores channel fields and direction
// [RULE5] Analog-configured pins read zero from port
// [RULE6] Digital-configured pins give no analog value
// [RULE7] Config register with direction decides pin mode
// [RULE8] Sixteen buffers then six control registers; buffer 8 sits at index 0x0530, past them
// [RULE9] Two-bit format field picks format
// [RULE10] 12-bit results widen to 16 bits
`timescale 1ns/1ns
`default_nettype none

module adc_result_format
    import adc_format_pkg::*;
#(
    parameter int ADDR_WIDTH = 16,               // APB byte address width
    parameter int PIN_COUNT  = 16                // Converter-capable port pins
) (
    input  wire logic                  core_clk,
    input  wire logic                  rst,
    input  wire logic [ADDR_WIDTH-1:0] paddr,
    input  wire logic                  psel,
    input  wire logic                  penable,
    input  wire logic                  pwrite,
    input  wire logic [31:0]           pwdata,
    input  wire logic [3:0]            pstrb,
    output logic      [31:0]           prdata,
    output logic                       pready,
    output logic                       pslverr,
    input  wire logic                  resultWrite,
    input  wire logic [3:0]            resultSlot,
    input  wire logic [RESULT_W-1:0]   resultValue,
    input  wire logic                  conversionDone,
    input  wire logic [PIN_COUNT-1:0]  portDirection,
    input  wire logic [PIN_COUNT-1:0]  portPinAsync,
    output logic      [PIN_COUNT-1:0]  portRead,
    output logic      [PIN_COUNT-1:0]  analogConnect,
    output logic      [PIN_COUNT-1:0]  convertDrivenLevel,
    output logic                       converterOn,
    output logic      [1:0]            outputFormat,
    output logic      [3:0]            positiveChannelSelectA,
    output logic      [3:0]            positiveChannelSelectB,
    output logic      [WORD_W-1:0]     controlTwo,
    output logic      [WORD_W-1:0]     controlThree,
    output logic      [WORD_W-1:0]     scanInputSelect
);

    // ========================================================================
    // Helper functions
    // ========================================================================

    // Byte address of a register index; indices are not word aligned
    function automatic logic [ADDR_WIDTH-1:0] byteAddr(input logic [15:0] idx);
        byteAddr = ADDR_WIDTH'({idx, 2'b00});
    endfunction : byteAddr

    // Widen a stored 12-bit result to a 16-bit bus word
    function automatic logic [WORD_W-1:0] formatResult(input logic [RESULT_W-1:0] raw,
                                                       input logic [1:0]          fmt);
        case (fmt)
            FMT_INTEGER:        formatResult = {{PAD_W{1'b0}}, raw};              // RULE1
            FMT_SIGNED_INTEGER: formatResult = {{PAD_W{raw[RESULT_W-1]}}, raw};   // RULE1
            FMT_FRACTIONAL:     formatResult = {raw, {PAD_W{1'b0}}};              // RULE1
            FMT_SIGNED_FRACT:   formatResult = {raw, {PAD_W{1'b0}}};              // RULE1
            default:            formatResult = {{PAD_W{1'b0}}, raw};
        endcase
    endfunction : formatResult

    // ========================================================================
    // Storage
    // ========================================================================
    logic [RESULT_W-1:0]  resultMem [BUF_COUNT];     // Result words, 12 bits each
    logic [WORD_W-1:0]    ctrlOne_q, ctrlOne_d;      // Enable, idle, format, trigger
    logic [WORD_W-1:0]    ctrlTwo_q, ctrlTwo_d;      // Reference, scan, interrupt rate
    logic [WORD_W-1:0]    ctrlThr_q, ctrlThr_d;      // Sample time, clock select
    logic [WORD_W-1:0]    chanSel_q, chanSel_d;      // Positive channel fields
    logic [WORD_W-1:0]    pinCfg_q,  pinCfg_d;       // 1 = digital, 0 = analog
    logic [WORD_W-1:0]    scanSel_q, scanSel_d;      // Scan input mask
    logic [31:0]          prdata_q,  prdata_d;       // Read data, held into access
    logic                 miss_q,    miss_d;         // Unmapped address seen in setup

    // ========================================================================
    // Address decode
    // ========================================================================
    logic                 setupPhase;                // First APB cycle
    logic                 accessPhase;               // Second APB cycle
    logic                 bufHit;                    // Address names a buffer word
    logic [3:0]           bufSlot;                   // Which buffer word
    logic                 regHit;                    // Any mapped register
    logic [WORD_W-1:0]    wrWord;                    // Low 16 bits of write data, before strobes
    logic [WORD_W-1:0]    laneMask;                  // Bits enabled by strobes

    assign setupPhase  = psel & ~penable;
    assign accessPhase = psel & penable;

    // Buffer lookup walks the index table; buffer 8 sits far from the rest
    always_comb begin
        bufHit  = 1'b0;
        bufSlot = 4'h0;
        for (int i = 0; i < BUF_COUNT; i++) begin
            if (paddr == byteAddr(BUF_IDX[i])) begin    // RULE8
                bufHit  = 1'b1;
                bufSlot = 4'(i);
            end
        end
    end

    // Mapped control registers follow the buffer block
    assign regHit = bufHit
                  | (paddr == byteAddr(CTRL_ONE_IDX))
                  | (paddr == byteAddr(CTRL_TWO_IDX))
                  | (paddr == byteAddr(CTRL_THR_IDX))
                  | (paddr == byteAddr(CHAN_SEL_IDX))
                  | (paddr == byteAddr(PIN_CFG_IDX))
                  | (paddr == byteAddr(SCAN_SEL_IDX));    // RULE8

    // Registers are 16 bits, so only the two low byte lanes matter
    assign laneMask = {{8{pstrb[1]}}, {8{pstrb[0]}}};

    // ========================================================================
    // Register write next-state
    // ========================================================================
    always_comb begin
        ctrlOne_d = ctrlOne_q;
        ctrlTwo_d = ctrlTwo_q;
        ctrlThr_d = ctrlThr_q;
        chanSel_d = chanSel_q;
        pinCfg_d  = pinCfg_q;
        scanSel_d = scanSel_q;
        wrWord    = pwdata[WORD_W-1:0];
        if (rst) begin
            ctrlOne_d = REG_RESET;
            ctrlTwo_d = REG_RESET;
            ctrlThr_d = REG_RESET;
            chanSel_d = REG_RESET;
            pinCfg_d  = REG_RESET;
            scanSel_d = REG_RESET;
        end else if (accessPhase && pwrite && !miss_q) begin
            // Buffer words are read-only: writes to them are dropped silently
            if (paddr == byteAddr(CTRL_ONE_IDX)) begin
                ctrlOne_d = (ctrlOne_q & ~(laneMask & CTRL_ONE_MASK)) | (wrWord & laneMask & CTRL_ONE_MASK);
            end
            if (paddr == byteAddr(CTRL_TWO_IDX)) begin
                ctrlTwo_d = (ctrlTwo_q & ~(laneMask & CTRL_TWO_MASK)) | (wrWord & laneMask & CTRL_TWO_MASK);
            end
            if (paddr == byteAddr(CTRL_THR_IDX)) begin
                ctrlThr_d = (ctrlThr_q & ~(laneMask & CTRL_THR_MASK)) | (wrWord & laneMask & CTRL_THR_MASK);
            end
            if (paddr == byteAddr(CHAN_SEL_IDX)) begin
                chanSel_d = (chanSel_q & ~(laneMask & CHAN_SEL_MASK)) | (wrWord & laneMask & CHAN_SEL_MASK);
            end
            if (paddr == byteAddr(PIN_CFG_IDX)) begin    // RULE7
                pinCfg_d = (pinCfg_q & ~laneMask) | (wrWord & laneMask);
            end
            if (paddr == byteAddr(SCAN_SEL_IDX)) begin
                scanSel_d = (scanSel_q & ~laneMask) | (wrWord & laneMask);
            end
        end
    end

    // Control registers only latch the computed next values
    always_ff @(posedge core_clk) begin
        ctrlOne_q <= ctrlOne_d;
        ctrlTwo_q <= ctrlTwo_d;
        ctrlThr_q <= ctrlThr_d;
        chanSel_q <= chanSel_d;
        pinCfg_q  <= pinCfg_d;
        scanSel_q <= scanSel_d;
    end

    // ========================================================================
    // Result buffer words
    // ========================================================================
    // No reset here on purpose: a reset leaves stored results untouched
    // Slot number is logical, so buffer 8 needs no special case here
    always_ff @(posedge core_clk) begin
        if (resultWrite) begin
            resultMem[resultSlot] <= resultValue;    // RULE10
        end
    end

    // ========================================================================
    // APB read path and answer
    // ========================================================================
    // Read data is captured in the setup cycle so prdata comes from a flop
    always_comb begin
        prdata_d = prdata_q;
        miss_d   = miss_q;
        if (rst) begin
            prdata_d = 32'h0000_0000;
            miss_d   = 1'b0;
        end else if (setupPhase) begin
            miss_d   = ~regHit;
            prdata_d = 32'h0000_0000;
            if (!pwrite) begin
                if (bufHit) begin
                    // Format is taken as the control word stands at setup
                    prdata_d[WORD_W-1:0] = formatResult(resultMem[bufSlot],
                                                        ctrlOne_q[FORM_LSB +: 2]);    // RULE9
                end else if (paddr == byteAddr(CTRL_ONE_IDX)) begin
                    // Done flag mirrors the sequencer; the stored bit 0 is never read back
                    prdata_d[WORD_W-1:0] = ctrlOne_q;
                    prdata_d[DONE_BIT]   = conversionDone;
                end else if (paddr == byteAddr(CTRL_TWO_IDX)) begin
                    prdata_d[WORD_W-1:0] = ctrlTwo_q;
                end else if (paddr == byteAddr(CTRL_THR_IDX)) begin
                    prdata_d[WORD_W-1:0] = ctrlThr_q;
                end else if (paddr == byteAddr(CHAN_SEL_IDX)) begin
                    prdata_d[WORD_W-1:0] = chanSel_q;
                end else if (paddr == byteAddr(PIN_CFG_IDX)) begin
                    prdata_d[WORD_W-1:0] = pinCfg_q;
                end else if (paddr == byteAddr(SCAN_SEL_IDX)) begin
                    prdata_d[WORD_W-1:0] = scanSel_q;
                end
            end
        end
    end

    // Read data and miss flag registers
    always_ff @(posedge core_clk) begin
        prdata_q <= prdata_d;
        miss_q   <= miss_d;
    end

    // Zero wait: every access phase completes at its first edge
    // A slave with wait states would need prdata_q held for longer; here the
    // capture at setup is enough because the answer always follows at once
    assign pready  = accessPhase;
    assign pslverr = accessPhase & miss_q;
    assign prdata  = prdata_q;

    // ========================================================================
    // Pin synchroniser and port read masking
    // ========================================================================
    logic [PIN_COUNT-1:0] pinMeta_q,  pinMeta_d;     // First stage, read only by second
    logic [PIN_COUNT-1:0] pinSync_q,  pinSync_d;     // Second stage, safe to use
    logic [PIN_COUNT-1:0] portRead_q, portRead_d;    // Masked port value
    logic [PIN_COUNT-1:0] analog_q,   analog_d;      // Pin feeds the converter
    logic [PIN_COUNT-1:0] driven_q,   driven_d;      // Converter sees driven level

    // Per-pin decision; each pin is independent so a generate loop does it
    // Limitation: the port value lags the pin by three edges, the price of
    // the two-stage synchroniser plus the masking register
    for (genvar p = 0; p < PIN_COUNT; p++) begin : g_pin
        always_comb begin
            pinMeta_d[p] = portPinAsync[p];
            pinSync_d[p] = pinMeta_q[p];
            if (rst) begin
                portRead_d[p] = 1'b0;
                analog_d[p]   = 1'b0;
                driven_d[p]   = 1'b0;
            end else begin
                // Analog pins hide their level from the digital port
                portRead_d[p] = pinSync_q[p] & pinCfg_q[p];     // RULE5
                // Only analog-configured pins reach the converter; the
                // channel fields and direction do not gate the switch
                analog_d[p]   = ~pinCfg_q[p];                   // RULE6 RULE7 RULE4
                // Software should set input direction; if not, the pin's
                // own output driver is what gets sampled
                driven_d[p]   = ~pinCfg_q[p] & ~portDirection[p];  // RULE3 RULE2
            end
        end
    end

    // Pin state registers
    always_ff @(posedge core_clk) begin
        pinMeta_q  <= pinMeta_d;
        pinSync_q  <= pinSync_d;
        portRead_q <= portRead_d;
        analog_q   <= analog_d;
        driven_q   <= driven_d;
    end

    // ========================================================================
    // Outputs to the sequencer and port logic
    // ========================================================================
    assign portRead               = portRead_q;
    assign analogConnect          = analog_q;
    assign convertDrivenLevel     = driven_q;
    assign converterOn            = ctrlOne_q[ON_BIT];              // RULE4
    assign outputFormat           = ctrlOne_q[FORM_LSB +: 2];
    assign positiveChannelSelectA = chanSel_q[CHSA_LSB +: 4];
    assign positiveChannelSelectB = chanSel_q[CHSB_LSB +: 4];
    assign controlTwo             = ctrlTwo_q;
    assign controlThree           = ctrlThr_q;
    assign scanInputSelect        = scanSel_q;

    // ========================================================================
    // Assertions
    // ========================================================================
    // Integer format: upper nibble zero one cycle after a buffer setup
    a_integer_zero_fill: assert property (@(posedge core_clk) disable iff (rst)  // RULE1
        (setupPhase && !pwrite && bufHit && ctrlOne_q[FORM_LSB +: 2] == FMT_INTEGER)
        |=> (prdata[WORD_W-1:RESULT_W] == 4'h0))
        else $error("integer format upper nibble not zero");

    // Signed integer: bits 15..11 all equal the stored sign bit
    a_signed_sign_copy: assert property (@(posedge core_clk) disable iff (rst)  // RULE1
        (setupPhase && !pwrite && bufHit && ctrlOne_q[FORM_LSB +: 2] == FMT_SIGNED_INTEGER)
        |=> (prdata[WORD_W-1:RESULT_W-1] == {5{prdata[RESULT_W-1]}}))
        else $error("signed integer sign not extended");

    // Fractional formats: low nibble zero
    a_fract_low_zero: assert property (@(posedge core_clk) disable iff (rst)  // RULE9
        (setupPhase && !pwrite && bufHit && ctrlOne_q[FORM_LSB + 1])
        |=> (prdata[PAD_W-1:0] == 4'h0))
        else $error("fractional format low nibble not zero");

    // Buffer reads never set bits above the 16-bit word
    a_word_width: assert property (@(posedge core_clk) disable iff (rst)  // RULE10
        pready && !pwrite && !pslverr |-> (prdata[31:WORD_W] == 16'h0000))
        else $error("read data wider than 16 bits");

    // Analog pins read zero at the port one edge later
    a_port_analog_zero: assert property (@(posedge core_clk) disable iff (rst)  // RULE5
        ##1 ((portRead & ~$past(pinCfg_q)) == '0))
        else $error("analog pin read nonzero on port");

    // Digital pins are disconnected from the converter
    a_digital_no_analog: assert property (@(posedge core_clk) disable iff (rst)  // RULE6
        ##1 ((analogConnect & $past(pinCfg_q)) == '0))
        else $error("digital pin connected to converter");

    // Driven level converted only for analog pins set to output
    a_output_dir_driven: assert property (@(posedge core_clk) disable iff (rst)  // RULE3
        ##1 (convertDrivenLevel == ($past(~pinCfg_q) & $past(~portDirection))))
        else $error("driven-level flag wrong for pin");

    // Connection does not follow a change of the channel fields
    a_select_indep: assert property (@(posedge core_clk) disable iff (rst)  // RULE4
        ($stable(pinCfg_q) && $changed(chanSel_q)) |=> $stable(analogConnect))
        else $error("analog connection followed channel select");

    // Config write lands and steers connection within two edges
    a_config_steers: assert property (@(posedge core_clk) disable iff (rst)  // RULE7
        (accessPhase && pwrite && paddr == byteAddr(PIN_CFG_IDX) && pstrb[1:0] == 2'b11)
        |=> (pinCfg_q == $past(pwdata[WORD_W-1:0])) ##1 (analogConnect == ~$past(pinCfg_q)))
        else $error("pin configuration write did not steer connection");

    // Mapped addresses never answer with an error
    a_map_no_error: assert property (@(posedge core_clk) disable iff (rst)  // RULE8
        (setupPhase && regHit) |=> (pready && !pslverr))
        else $error("mapped register answered with error");

    // Unmapped addresses answer with an error and read zero
    a_miss_reads_zero: assert property (@(posedge core_clk) disable iff (rst)  // RULE8
        (setupPhase && !regHit)
        |=> (pready && pslverr && prdata == 32'h0000_0000))
        else $error("unmapped register did not answer with error");

    // Done bit of a control-one read follows the sequencer level at setup
    a_done_mirror: assert property (@(posedge core_clk) disable iff (rst)  // RULE8
        (setupPhase && !pwrite && paddr == byteAddr(CTRL_ONE_IDX))
        |=> (prdata[DONE_BIT] == $past(conversionDone)))
        else $error("done bit did not follow the sequencer");

    // Leaving reset: every pin analog, converter off, port reads zero
    // Checked at release only, so the first edges before reset are ignored
    a_reset_all_analog: assert property (@(posedge core_clk)  // RULE7
        ($past(rst) && !rst)
        |-> (pinCfg_q == REG_RESET && !converterOn && portRead == '0))
        else $error("reset did not return pins to analog");

endmodule : adc_result_format

`default_nettype wire

// [bench/adc_result_format_tb.sv]
/*
 * Self-checking bench for the converter result format and pin configuration block.
 * Assumes adc_format_pkg is compiled first and a zero-wait APB slave on core_clk.
 */
`timescale 1ns/1ns
`default_nettype none

module adc_result_format_tb import adc_format_pkg::*;;

    // ========================================================================
    // Signals
    // ========================================================================
    logic        core_clk, rst, psel, penable, pwrite, pready, pslverr, err;
    logic        resultWrite, conversionDone, converterOn;
    logic [15:0] paddr, portDirection, portPinAsync, portRead, analogConnect, convertDrivenLevel;
    logic [31:0] pwdata, prdata, rd;
    logic [3:0]  pstrb, resultSlot, chanA, chanB;
    logic [11:0] resultValue;
    logic [1:0]  outputFormat;
    logic [15:0] ctrlTwo, ctrlThree, scanSel;
    int          badCount, cmpCount;
    // Control registers in map order, with the bits that read back a written one
    localparam logic [15:0] CTRL_IDX [6] = '{CTRL_ONE_IDX, CTRL_TWO_IDX, CTRL_THR_IDX,
                                             CHAN_SEL_IDX, PIN_CFG_IDX, SCAN_SEL_IDX};
    localparam logic [15:0] CTRL_MSK [6] = '{CTRL_ONE_MASK & 16'hFFFE, CTRL_TWO_MASK, CTRL_THR_MASK,
                                             CHAN_SEL_MASK, FULL_MASK, FULL_MASK};

    adc_result_format adc_result_format_inst (
        .core_clk(core_clk), .rst(rst), .paddr(paddr), .psel(psel), .penable(penable),
        .pwrite(pwrite), .pwdata(pwdata), .pstrb(pstrb), .prdata(prdata), .pready(pready),
        .pslverr(pslverr), .resultWrite(resultWrite), .resultSlot(resultSlot),
        .resultValue(resultValue), .conversionDone(conversionDone), .portDirection(portDirection),
        .portPinAsync(portPinAsync), .portRead(portRead), .analogConnect(analogConnect),
        .convertDrivenLevel(convertDrivenLevel), .converterOn(converterOn),
        .outputFormat(outputFormat), .positiveChannelSelectA(chanA), .positiveChannelSelectB(chanB),
        .controlTwo(ctrlTwo), .controlThree(ctrlThree), .scanInputSelect(scanSel)
    );

    // ========================================================================
    // Clock, 40 ns period
    // ========================================================================
    always #20 core_clk = ~core_clk;

    // ========================================================================
    // Helpers
    // ========================================================================
    // Compare and count; four-state, so an unknown bit matches only an expected unknown
    task automatic check(input logic [31:0] seen, input logic [31:0] exp);
        cmpCount++;
        if (seen !== exp) begin
            badCount++;
            $display("BAD %0t seen %h expected %h", $time, seen, exp);
        end
    endtask : check

    task automatic printVerdict;
        $display("Counts: %0d mismatches in %0d comparisons", badCount, cmpCount);
        if (badCount == 0 && cmpCount > 0) begin
            $display("Simulation passed");
        end else begin
            $display("Simulation failed");
        end
        $finish;
    endtask : printVerdict

    // One APB transfer; request held until pready is sampled high
    task automatic apb(input logic [15:0] idx, input logic wr, input logic [31:0] wd);
        int n;
        @(posedge core_clk);
        psel    <= 1'b1;
        penable <= 1'b0;
        paddr   <= {idx[13:0], 2'b00};   // Byte address is four times the index
        pwrite  <= wr;
        pwdata  <= wd;
        @(posedge core_clk);
        penable <= 1'b1;
        n = 0;
        @(posedge core_clk);
        while (pready !== 1'b1) begin   // Bounded wait, no latency assumed
            n++;
            if (n > 16) begin
                badCount++;
                printVerdict();
            end
            @(posedge core_clk);
        end
        rd = prdata;
        err = pslverr;
        psel    <= 1'b0;
        penable <= 1'b0;
    endtask : apb

    // Result value stored in each buffer slot; slot 8 and up are negative
    function automatic logic [11:0] slotVal(input int k);
        return 12'h5A3 ^ {k[3:0], k[3:0], k[3:0]};
    endfunction : slotVal

    // Bus word expected for a 12-bit result in a given format
    function automatic logic [31:0] fmtExp(input logic [1:0] f, input logic [11:0] v);
        case (f)
            2'h0:    return {20'h0_0000, v};
            2'h1:    return {16'h0000, {4{v[11]}}, v};
            default: return {16'h0000, v, 4'h0};
        endcase
    endfunction : fmtExp

    // ========================================================================
    // Main sequence
    // ========================================================================
    initial begin
        core_clk = 0; rst = 1; psel = 0; penable = 0; pwrite = 0; paddr = '0;
        pwdata = '0; pstrb = 4'hF; resultWrite = 0; resultSlot = '0; resultValue = '0;
        conversionDone = 0; portDirection = 16'hFFFF; portPinAsync = 16'h0A50;
        badCount = 0; cmpCount = 0; rd = '0; err = 0;
        repeat (6) @(posedge core_clk);
        rst <= 1'b0;
        // Reset values, then write ones and read back implemented bits
        for (int i = 0; i < 6; i++) begin
            apb(CTRL_IDX[i], 1'b0, 32'h0);
            check(rd, 32'h0000_0000);
            apb(CTRL_IDX[i], 1'b1, 32'hFFFF_FFFF);
            apb(CTRL_IDX[i], 1'b0, 32'h0);
            check(rd, {16'h0000, CTRL_MSK[i]});
        end
        check({converterOn, outputFormat, chanA, chanB}, 32'h0000_07FF);
        check({ctrlTwo, ctrlThree}, {CTRL_TWO_MASK, CTRL_THR_MASK});
        check({16'h0000, scanSel}, {16'h0000, FULL_MASK});
        // Done status comes from the sequencer, not from storage
        conversionDone <= 1'b1;
        apb(CTRL_ONE_IDX, 1'b0, 32'h0);
        check(rd, {16'h0000, CTRL_ONE_MASK});
        // Unmapped index between buffers answers with an error and zero
        apb(16'h0281, 1'b0, 32'h0);
        check({31'h0000_0000, err}, 32'h0000_0001);
        check(rd, 32'h0000_0000);
        // Fill every buffer slot from the sequencer side
        for (int k = 0; k < BUF_COUNT; k++) begin
            @(posedge core_clk);
            resultWrite <= 1'b1;
            resultSlot  <= 4'(k);
            resultValue <= slotVal(k);
        end
        @(posedge core_clk);
        resultWrite <= 1'b0;
        // Buffer words are read-only; this write must leave slot 0 alone
        apb(BUF_IDX[0], 1'b1, 32'h0000_0000);
        for (int f = 0; f < 4; f++) begin
            apb(CTRL_ONE_IDX, 1'b1, 32'(f) << FORM_LSB);
            for (int k = 0; k < BUF_COUNT; k++) begin
                apb(BUF_IDX[k], 1'b0, 32'h0);
                check(rd, fmtExp(2'(f), slotVal(k)));
            end
        end
        // Upper byte analog, low nibble and bits 7:4 mixed; some pins driven
        apb(PIN_CFG_IDX, 1'b1, 32'h0000_00F0);
        portDirection <= 16'h0F0F;
        repeat (4) @(posedge core_clk);
        check(portRead, 16'h0050);
        check(analogConnect, 16'hFF0F);
        check(convertDrivenLevel, 16'hF000);
        // Channel fields and directions do not gate the analog path
        apb(CHAN_SEL_IDX, 1'b1, 32'h0000_0000);
        portDirection <= 16'hFFFF;
        repeat (4) @(posedge core_clk);
        check(analogConnect, 16'hFF0F);
        check(convertDrivenLevel, 16'h0000);
        printVerdict();
    end

endmodule : adc_result_format_tb

`default_nettype wire
